//--- include/piodm_pkg.sv
// Package for the general I/O default memory map block
// Summary of operation
// RULE1 - Addresses 000h-0FFh are read/write user memory, four 64-byte blocks.
// RULE2 - 100h-109h, 110h-117h, 128h-133h and 136h upward are reserved, undefined reads.
// RULE3 - Default output levels held at default_out_level_lo (lines 0-7) and default_out_level_hi (8-11).
// RULE4 - Default directions held at default_direction_lo (lines 0-7) and default_direction_hi (8-11).
// RULE5 - default_invert_lo holds default inversion 0-7; default_invert_type_mode inversion 8-11, types, mode.
// RULE6 - 64-bit registration number at 118h-11Fh, read-only.
// RULE7 - Volatile working registers out_level_lo-invert_type_mode mirror the default layout.
// RULE8 - Sensed line levels read at line_sense_lo and line_sense_hi, read-only.
// RULE9 - Alarm/status at alarm_status is battery-backed, readable, host can only clear it.
// RULE10 - Power-up copies default levels into out_level_lo/out_level_hi.
// RULE11 - Power-up copies default directions into direction_lo/direction_hi.
// RULE12 - Power-up copies default inversion default_invert_lo into invert_lo.
// RULE13 - Shipped default levels are FFh low and 0Fh high.
// RULE14 - Shipped default directions are FFh low and 0Fh high.
// RULE15 - Shipped default inversion for lines 0-7 is 00h.
// RULE16 - Direction bit 0 makes an output, 1 makes an input.
// RULE17 - Inversion bit 0 passes level, 1 inverts it on read.
// RULE18 - Bit n controls line n in low byte, line 8+n in high byte.
// RULE19 - Bits 7:4 of high level and direction defaults are reserved.
// RULE20 - Host reads and writes default level, direction, inversion freely.
// RULE21 - default_invert_type_mode: bits 3:0 inversion 8-11, bits 6:4 group types, bit 7 mode.
// RULE22 - Power-up copies default_invert_type_mode into invert_type_mode; default_invert_type_mode ships as 80h.
// RULE23 - Writes to reserved, read-only and registration addresses change nothing.
package piodm_pkg;
  localparam int ADDR_W = 9;
  localparam int LINES = 12;
  localparam int SYNC_STAGES = 2;
  // Address map
  localparam logic [8:0] USER_LAST = 9'h0ff;
  localparam logic [8:0] DEF_LEVEL_LO = 9'h10a;
  localparam logic [8:0] DEF_LEVEL_HI = 9'h10b;
  localparam logic [8:0] DEF_DIR_LO = 9'h10c;
  localparam logic [8:0] DEF_DIR_HI = 9'h10d;
  localparam logic [8:0] DEF_INV_LO = 9'h10e;
  localparam logic [8:0] DEF_INV_TYPE_MODE = 9'h10f;
  localparam logic [8:0] REGNUM_FIRST = 9'h118;
  localparam logic [8:0] REGNUM_LAST = 9'h11f;
  localparam logic [8:0] OUT_LEVEL_LO = 9'h120;
  localparam logic [8:0] OUT_LEVEL_HI = 9'h121;
  localparam logic [8:0] DIRECTION_LO = 9'h122;
  localparam logic [8:0] DIRECTION_HI = 9'h123;
  localparam logic [8:0] INVERT_LO = 9'h124;
  localparam logic [8:0] INVERT_TYPE_MODE = 9'h125;
  localparam logic [8:0] LINE_SENSE_LO = 9'h126;
  localparam logic [8:0] LINE_SENSE_HI = 9'h127;
  localparam logic [8:0] MULTIFUNCTION_SETUP = 9'h134;
  localparam logic [8:0] ALARM_STATUS = 9'h135;
  // Field positions in the invert/type/mode byte
  localparam int TYPE_LSB = 4;
  localparam int MODE_BIT = 7;
  // Shipped values, battery-backed reset value and undefined read value
  localparam logic [7:0] SHIP_LEVEL_LO = 8'hff;
  localparam logic [3:0] SHIP_LEVEL_HI = 4'hf;
  localparam logic [7:0] SHIP_DIR_LO = 8'hff;
  localparam logic [3:0] SHIP_DIR_HI = 4'hf;
  localparam logic [7:0] SHIP_INV_LO = 8'h00;
  localparam logic [7:0] SHIP_INV_TYPE_MODE = 8'h80;
  localparam logic [7:0] BATT_RESET_VAL = 8'h00;
  localparam logic [7:0] UNDEF_READ = 8'h00;
  // Address classes and controller states
  typedef enum logic [2:0] {
    AC_USER = 3'd0,
    AC_DEFAULT = 3'd1,
    AC_REGNUM = 3'd2,
    AC_WORK = 3'd3,
    AC_SENSE = 3'd4,
    AC_BATT = 3'd5,
    AC_RSVD = 3'd6
  } piodm_class_t;
  typedef enum logic [1:0] {
    ST_COPY = 2'b01,
    ST_RUN = 2'b10
  } piodm_state_t;
endpackage

//--- hdl/piodm_map.sv
// Register bank and address decoder for the general I/O default memory map
`timescale 1ns/10ps
module piodm_map #(
  // Registration number; byte at 118h+k is bits 8k+7:8k. Value is arbitrary.
  parameter logic [63:0] REG_NUMBER = 64'h1234_5678_9abc_de5a,
  parameter int USER_BYTES = 256
) (
  // Clock and resets
  input wire logic clk,
  input wire logic rst_b,
  input wire logic batt_rst_b,
  input wire logic factory_load,
  // Byte access from the serial front end
  input wire logic [8:0] acc_addr,
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [7:0] acc_wdata,
  output logic [7:0] acc_rdata,
  output logic acc_rvalid,
  output logic acc_ready,
  // Alarm events
  input wire logic [7:0] alarm_set,
  // General I/O lines
  input wire logic [11:0] general_io_line_in,
  output logic [11:0] general_io_line_out,
  output logic [11:0] general_io_line_oe,
  output logic drive_mode,
  output logic [7:0] multifunction_setup
);

  function automatic piodm_pkg::piodm_class_t addr_class(input logic [8:0] a);
    if (a <= piodm_pkg::USER_LAST) begin
      return piodm_pkg::AC_USER; // RULE1
    end else if (a >= piodm_pkg::DEF_LEVEL_LO && a <= piodm_pkg::DEF_INV_TYPE_MODE) begin
      return piodm_pkg::AC_DEFAULT;
    end else if (a >= piodm_pkg::REGNUM_FIRST && a <= piodm_pkg::REGNUM_LAST) begin
      return piodm_pkg::AC_REGNUM;
    end else if (a >= piodm_pkg::OUT_LEVEL_LO && a <= piodm_pkg::INVERT_TYPE_MODE) begin
      return piodm_pkg::AC_WORK;
    end else if (a == piodm_pkg::LINE_SENSE_LO || a == piodm_pkg::LINE_SENSE_HI) begin
      return piodm_pkg::AC_SENSE;
    end else if (a == piodm_pkg::MULTIFUNCTION_SETUP || a == piodm_pkg::ALARM_STATUS) begin
      return piodm_pkg::AC_BATT;
    end else begin
      return piodm_pkg::AC_RSVD; // RULE2
    end
  endfunction

  piodm_pkg::piodm_state_t state_r;
  logic [7:0] user_mem [USER_BYTES];
  logic [7:0] def_level_lo_r;
  logic [3:0] def_level_hi_r;
  logic [7:0] def_dir_lo_r;
  logic [3:0] def_dir_hi_r;
  logic [7:0] def_inv_lo_r;
  logic [7:0] def_inv_type_mode_r;
  logic [11:0] out_level_r;
  logic [11:0] direction_r;
  logic [7:0] invert_lo_r;
  logic [7:0] invert_type_mode_r;
  logic [7:0] multi_setup_r;
  logic [7:0] alarm_status_r;
  logic [11:0] sense_meta_r;
  logic [11:0] sense_r;
  logic [11:0] invert_all;
  logic [11:0] sensed;
  logic [7:0] rdata_nxt;
  logic [7:0] acc_rdata_r;
  logic acc_rvalid_r;
  logic wr_ok;
  logic rd_ok;
  piodm_pkg::piodm_class_t wr_class;
  piodm_pkg::piodm_class_t rd_class;

  assign wr_class = addr_class(acc_addr);
  assign rd_class = wr_class;
  assign acc_ready = (state_r == piodm_pkg::ST_RUN);
  assign wr_ok = acc_wr && acc_ready;
  assign rd_ok = acc_rd && acc_ready;

  // One copy cycle after every power-up reset, accesses held off meanwhile
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= piodm_pkg::ST_COPY;
    end else begin
      unique case (state_r)
        piodm_pkg::ST_COPY: begin
          state_r <= piodm_pkg::ST_RUN;
        end
        piodm_pkg::ST_RUN: begin
          state_r <= piodm_pkg::ST_RUN;
        end
        default: begin
          state_r <= piodm_pkg::ST_COPY;
        end
      endcase
    end
  end

  // User memory keeps its contents across reset
  always_ff @(posedge clk) begin
    if (wr_ok && wr_class == piodm_pkg::AC_USER) begin
      user_mem[acc_addr[7:0]] <= acc_wdata; // RULE1
    end
  end

  // Nonvolatile defaults survive rst_b; factory_load restores shipped values
  always_ff @(posedge clk) begin
    if (factory_load) begin
      def_level_lo_r <= piodm_pkg::SHIP_LEVEL_LO; // RULE13
      def_level_hi_r <= piodm_pkg::SHIP_LEVEL_HI; // RULE13
      def_dir_lo_r <= piodm_pkg::SHIP_DIR_LO; // RULE14
      def_dir_hi_r <= piodm_pkg::SHIP_DIR_HI; // RULE14
      def_inv_lo_r <= piodm_pkg::SHIP_INV_LO; // RULE15
      def_inv_type_mode_r <= piodm_pkg::SHIP_INV_TYPE_MODE; // RULE22
    end else if (wr_ok && wr_class == piodm_pkg::AC_DEFAULT) begin
      unique case (acc_addr)
        piodm_pkg::DEF_LEVEL_LO: def_level_lo_r <= acc_wdata; // RULE3
        piodm_pkg::DEF_LEVEL_HI: def_level_hi_r <= acc_wdata[3:0]; // RULE19
        piodm_pkg::DEF_DIR_LO: def_dir_lo_r <= acc_wdata; // RULE4
        piodm_pkg::DEF_DIR_HI: def_dir_hi_r <= acc_wdata[3:0]; // RULE19
        piodm_pkg::DEF_INV_LO: def_inv_lo_r <= acc_wdata; // RULE20
        default: def_inv_type_mode_r <= acc_wdata; // RULE5
      endcase
    end
  end

  // Working registers: loaded from defaults in the copy cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_level_r <= '0;
      direction_r <= '1;
      invert_lo_r <= '0;
      invert_type_mode_r <= '0;
    end else if (state_r == piodm_pkg::ST_COPY) begin
      out_level_r <= {def_level_hi_r, def_level_lo_r}; // RULE10
      direction_r <= {def_dir_hi_r, def_dir_lo_r}; // RULE11
      invert_lo_r <= def_inv_lo_r; // RULE12
      invert_type_mode_r <= def_inv_type_mode_r; // RULE22
    end else if (wr_ok && wr_class == piodm_pkg::AC_WORK) begin
      unique case (acc_addr)
        piodm_pkg::OUT_LEVEL_LO: out_level_r[7:0] <= acc_wdata; // RULE7
        piodm_pkg::OUT_LEVEL_HI: out_level_r[11:8] <= acc_wdata[3:0]; // RULE7
        piodm_pkg::DIRECTION_LO: direction_r[7:0] <= acc_wdata;
        piodm_pkg::DIRECTION_HI: direction_r[11:8] <= acc_wdata[3:0];
        piodm_pkg::INVERT_LO: invert_lo_r <= acc_wdata;
        default: invert_type_mode_r <= acc_wdata;
      endcase
    end
  end

  // Battery-backed registers ride through rst_b; batt_rst_b is their only reset
  always_ff @(posedge clk) begin
    if (!batt_rst_b) begin
      multi_setup_r <= piodm_pkg::BATT_RESET_VAL;
    end else if (wr_ok && acc_addr == piodm_pkg::MULTIFUNCTION_SETUP) begin
      multi_setup_r <= acc_wdata;
    end
  end

  // Write-one-to-clear; a new event in the same cycle keeps its bit
  always_ff @(posedge clk) begin
    if (!batt_rst_b) begin
      alarm_status_r <= piodm_pkg::BATT_RESET_VAL;
    end else if (wr_ok && acc_addr == piodm_pkg::ALARM_STATUS) begin
      alarm_status_r <= (alarm_status_r & ~acc_wdata) | alarm_set; // RULE9
    end else begin
      alarm_status_r <= alarm_status_r | alarm_set; // RULE9
    end
  end

  // Pin synchroniser
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sense_meta_r <= '0;
      sense_r <= '0;
    end else begin
      sense_meta_r <= general_io_line_in;
      sense_r <= sense_meta_r;
    end
  end

  assign invert_all = {invert_type_mode_r[3:0], invert_lo_r}; // RULE18
  assign sensed = sense_r ^ invert_all; // RULE17

  // Read mux; undefined locations read as zero
  always_comb begin
    rdata_nxt = piodm_pkg::UNDEF_READ; // RULE2
    unique case (rd_class)
      piodm_pkg::AC_USER: rdata_nxt = user_mem[acc_addr[7:0]];
      piodm_pkg::AC_DEFAULT: begin
        unique case (acc_addr)
          piodm_pkg::DEF_LEVEL_LO: rdata_nxt = def_level_lo_r;
          piodm_pkg::DEF_LEVEL_HI: rdata_nxt = {4'h0, def_level_hi_r}; // RULE19
          piodm_pkg::DEF_DIR_LO: rdata_nxt = def_dir_lo_r;
          piodm_pkg::DEF_DIR_HI: rdata_nxt = {4'h0, def_dir_hi_r}; // RULE19
          piodm_pkg::DEF_INV_LO: rdata_nxt = def_inv_lo_r;
          default: rdata_nxt = def_inv_type_mode_r; // RULE21
        endcase
      end
      piodm_pkg::AC_REGNUM: rdata_nxt = REG_NUMBER[8 * acc_addr[2:0] +: 8]; // RULE6
      piodm_pkg::AC_WORK: begin
        unique case (acc_addr)
          piodm_pkg::OUT_LEVEL_LO: rdata_nxt = out_level_r[7:0];
          piodm_pkg::OUT_LEVEL_HI: rdata_nxt = {4'h0, out_level_r[11:8]};
          piodm_pkg::DIRECTION_LO: rdata_nxt = direction_r[7:0];
          piodm_pkg::DIRECTION_HI: rdata_nxt = {4'h0, direction_r[11:8]};
          piodm_pkg::INVERT_LO: rdata_nxt = invert_lo_r;
          default: rdata_nxt = invert_type_mode_r;
        endcase
      end
      piodm_pkg::AC_SENSE: begin
        if (acc_addr == piodm_pkg::LINE_SENSE_LO) begin
          rdata_nxt = sensed[7:0]; // RULE8
        end else begin
          rdata_nxt = {4'h0, sensed[11:8]}; // RULE8
        end
      end
      piodm_pkg::AC_BATT: begin
        if (acc_addr == piodm_pkg::ALARM_STATUS) begin
          rdata_nxt = alarm_status_r;
        end else begin
          rdata_nxt = multi_setup_r;
        end
      end
      default: rdata_nxt = piodm_pkg::UNDEF_READ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acc_rdata_r <= '0;
      acc_rvalid_r <= 1'b0;
    end else begin
      acc_rvalid_r <= rd_ok;
      if (rd_ok) begin
        acc_rdata_r <= rdata_nxt;
      end
    end
  end

  assign acc_rdata = acc_rdata_r;
  assign acc_rvalid = acc_rvalid_r;
  assign drive_mode = invert_type_mode_r[piodm_pkg::MODE_BIT];
  assign multifunction_setup = multi_setup_r;

  // Drivers: group type bit selects open drain for four lines each
  for (genvar n = 0; n < piodm_pkg::LINES; n++) begin : g_line
    logic open_drain;
    assign open_drain = invert_type_mode_r[piodm_pkg::TYPE_LSB + n / 4]; // RULE21
    assign general_io_line_out[n] = out_level_r[n];
    // Open drain only pulls low; it never drives a high
    assign general_io_line_oe[n] = !direction_r[n] && (!open_drain || !out_level_r[n]); // RULE16
  end

  chk_copy_levels: assert property (@(posedge clk) disable iff (!rst_b) // RULE10
    rst_b && state_r == piodm_pkg::ST_COPY
      |=> out_level_r == $past({def_level_hi_r, def_level_lo_r}))
    else $error("working levels not loaded from defaults");
  chk_copy_dirs: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
    rst_b && state_r == piodm_pkg::ST_COPY
      |=> direction_r == $past({def_dir_hi_r, def_dir_lo_r}))
    else $error("working directions not loaded from defaults");
  chk_copy_invert: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
    rst_b && state_r == piodm_pkg::ST_COPY
      |=> invert_lo_r == $past(def_inv_lo_r) && invert_type_mode_r == $past(def_inv_type_mode_r))
    else $error("working inversion not loaded from defaults");
  chk_input_no_drive: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
    (general_io_line_oe & direction_r) == 12'h000)
    else $error("input line is driven");
  chk_sense_read: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
    rd_ok && acc_addr == piodm_pkg::LINE_SENSE_LO |=> acc_rvalid && acc_rdata == $past(sensed[7:0]))
    else $error("sense read wrong");
  chk_hi_reserved: assert property (@(posedge clk) disable iff (!rst_b) // RULE19
    rd_ok && (acc_addr == piodm_pkg::DEF_LEVEL_HI || acc_addr == piodm_pkg::DEF_DIR_HI)
      |=> acc_rdata[7:4] == 4'h0)
    else $error("reserved high bits not zero");
  chk_default_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE20
    wr_ok && !factory_load && acc_addr == piodm_pkg::DEF_LEVEL_LO |=> def_level_lo_r == $past(acc_wdata))
    else $error("default level write lost");
  chk_ro_ignored: assert property (@(posedge clk) disable iff (!rst_b) // RULE23
    wr_ok && (wr_class == piodm_pkg::AC_RSVD || wr_class == piodm_pkg::AC_SENSE
      || wr_class == piodm_pkg::AC_REGNUM)
      |=> $stable(out_level_r) && $stable(direction_r) && $stable(invert_type_mode_r))
    else $error("read-only write changed state");
  chk_regnum_read: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    rd_ok && acc_addr == piodm_pkg::REGNUM_LAST |=> acc_rdata == REG_NUMBER[63:56])
    else $error("registration byte wrong");
  chk_alarm_clear: assert property (@(posedge clk) disable iff (!batt_rst_b) // RULE9
    wr_ok && acc_addr == piodm_pkg::ALARM_STATUS
      |=> alarm_status_r == (($past(alarm_status_r) & ~$past(acc_wdata)) | $past(alarm_set)))
    else $error("alarm clear wrong");
  chk_reserved_read: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
    rd_ok && rd_class == piodm_pkg::AC_RSVD |=> acc_rdata == piodm_pkg::UNDEF_READ)
    else $error("reserved read not zero");

  // Group type bits spread to their four lines, for the drive checks
  logic [11:0] open_drain_mask;
  assign open_drain_mask = {{4{invert_type_mode_r[piodm_pkg::TYPE_LSB + 2]}},
    {4{invert_type_mode_r[piodm_pkg::TYPE_LSB + 1]}}, {4{invert_type_mode_r[piodm_pkg::TYPE_LSB]}}};

  chk_user_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
    wr_ok && wr_class == piodm_pkg::AC_USER
      |=> user_mem[$past(acc_addr[7:0])] == $past(acc_wdata))
    else $error("user byte write lost");
  chk_work_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
    wr_ok && acc_addr == piodm_pkg::OUT_LEVEL_LO |=> out_level_r[7:0] == $past(acc_wdata))
    else $error("working level write lost");
  chk_dir_hi_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
    wr_ok && acc_addr == piodm_pkg::DIRECTION_HI
      |=> direction_r[11:8] == $past(acc_wdata[3:0]))
    else $error("working direction write lost");
  chk_def_dir_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
    wr_ok && !factory_load && acc_addr == piodm_pkg::DEF_DIR_LO
      |=> def_dir_lo_r == $past(acc_wdata))
    else $error("default direction write lost");
  chk_alarm_set: assert property (@(posedge clk) disable iff (!batt_rst_b) // RULE9
    alarm_set != 8'h00 |=> (alarm_status_r & $past(alarm_set)) == $past(alarm_set))
    else $error("alarm event not latched");
  chk_ship_levels: assert property (@(posedge clk) disable iff (!rst_b) // RULE13
    factory_load |=> def_level_lo_r == piodm_pkg::SHIP_LEVEL_LO
      && def_level_hi_r == piodm_pkg::SHIP_LEVEL_HI)
    else $error("shipped levels not loaded");
  chk_ship_dirs: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
    factory_load |=> def_dir_lo_r == piodm_pkg::SHIP_DIR_LO
      && def_dir_hi_r == piodm_pkg::SHIP_DIR_HI)
    else $error("shipped directions not loaded");
  chk_ship_invert: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
    factory_load |=> def_inv_lo_r == piodm_pkg::SHIP_INV_LO)
    else $error("shipped inversion not loaded");
  chk_ship_mode: assert property (@(posedge clk) disable iff (!rst_b) // RULE22
    factory_load |=> def_inv_type_mode_r == piodm_pkg::SHIP_INV_TYPE_MODE)
    else $error("shipped type and mode not loaded");
  chk_od_no_high: assert property (@(posedge clk) disable iff (!rst_b) // RULE21
    (general_io_line_oe & out_level_r & open_drain_mask) == 12'h000)
    else $error("open-drain line driven high");
  chk_pp_drives: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
    (~direction_r & ~open_drain_mask & ~general_io_line_oe) == 12'h000)
    else $error("push-pull output not driven");
  chk_sense_hi: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
    rd_ok && acc_addr == piodm_pkg::LINE_SENSE_HI
      |=> acc_rvalid && acc_rdata == {4'h0, $past(sensed[11:8])})
    else $error("high sense read wrong");
  chk_regnum_first: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    rd_ok && acc_addr == piodm_pkg::REGNUM_FIRST |=> acc_rdata == REG_NUMBER[7:0])
    else $error("first registration byte wrong");
endmodule

//--- tb/piodm_pins.sv
// Pin load model for the twelve general I/O lines
`timescale 1ns/10ps
module piodm_pins (
  // Design drive
  input wire logic [11:0] line_out,
  input wire logic [11:0] line_oe,
  // External drivers on the board
  input wire logic [11:0] ext_drive,
  input wire logic [11:0] ext_en,
  // Resolved line level
  output logic [11:0] line_level
);
  // Undriven lines sit at the pull-up, so released open-drain lines read 1
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (line_oe[i]) begin
        line_level[i] = line_out[i];
      end else if (ext_en[i]) begin
        line_level[i] = ext_drive[i];
      end else begin
        line_level[i] = 1'b1;
      end
    end
  end
endmodule

//--- tb/pio_default_memory_map_test.sv
// Self-checking testbench for the general I/O default memory map block
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
  end \
end
module pio_default_memory_map_test;
  // Value is arbitrary
  localparam logic [63:0] REG_NUMBER = 64'h0f1e_2d3c_4b5a_6978;
  localparam logic [7:0] SHIP [6] = '{8'hff, 8'h0f, 8'hff, 8'h0f, 8'h00, 8'h80};
  localparam logic [7:0] WV [6] = '{8'h5a, 8'hf3, 8'h0f, 8'hfa, 8'h3c, 8'h71};
  localparam logic [7:0] EV [6] = '{8'h5a, 8'h03, 8'h0f, 8'h0a, 8'h3c, 8'h71};
  localparam logic [8:0] UA [6] = '{9'h000, 9'h03f, 9'h040, 9'h07f, 9'h080, 9'h0ff};
  localparam logic [8:0] RSV [7] = '{9'h100, 9'h109, 9'h110, 9'h117, 9'h128, 9'h136, 9'h1ff};
  logic clk, rst_b, batt_rst_b, factory_load, acc_wr, acc_rd;
  logic [8:0] acc_addr;
  logic [7:0] acc_wdata, alarm_set, acc_rdata, mf_setup, rd_data;
  logic acc_rvalid, acc_ready, drive_mode;
  logic [11:0] line_out, line_oe, line_level, ext_drive, ext_en;
  int errors, tests_run;

  piodm_map #(.REG_NUMBER(REG_NUMBER), .USER_BYTES(256)) i_dut (
    .clk(clk), .rst_b(rst_b), .batt_rst_b(batt_rst_b), .factory_load(factory_load),
    .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .acc_ready(acc_ready),
    .alarm_set(alarm_set), .general_io_line_in(line_level),
    .general_io_line_out(line_out), .general_io_line_oe(line_oe),
    .drive_mode(drive_mode), .multifunction_setup(mf_setup)
  );
  piodm_pins i_pins (
    .line_out(line_out), .line_oe(line_oe), .ext_drive(ext_drive), .ext_en(ext_en),
    .line_level(line_level)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (acc_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 50) begin
      errors++;
      $display("MISMATCH acc_ready expected 1 seen %b", acc_ready);
      tally_and_finish();
    end
  endtask

  // Strobe raised at one edge, taken at the next, then dropped
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    wait_ready();
    @(posedge clk);
    acc_addr <= a;
    acc_wdata <= d;
    acc_wr <= 1'b1;
    @(posedge clk);
    acc_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [8:0] a, input logic [7:0] exp, input string nm);
    wait_ready();
    @(posedge clk);
    acc_addr <= a;
    acc_rd <= 1'b1;
    @(posedge clk);
    acc_rd <= 1'b0;
    #1;
    `CHK("acc_rvalid", 1'b1, acc_rvalid)
    rd_data = acc_rdata;
    `CHK(nm, exp, rd_data)
  endtask

  task automatic pwr_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    wait_ready();
  endtask

  initial begin
    rst_b = 1'b0;
    batt_rst_b = 1'b0;
    factory_load = 1'b1;
    acc_addr = 9'h000;
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_wdata = 8'h00;
    alarm_set = 8'h00;
    ext_drive = 12'h000;
    ext_en = 12'h000;
    errors = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    batt_rst_b <= 1'b1;
    wait_ready();
    @(posedge clk);
    factory_load <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rchk(piodm_pkg::DEF_LEVEL_LO + 9'(i), SHIP[i], "ship_default");
      rchk(piodm_pkg::OUT_LEVEL_LO + 9'(i), SHIP[i], "ship_copy");
    end
    `CHK("line_oe", 12'h000, line_oe)
    `CHK("drive_mode", 1'b1, drive_mode)
    $display("Test shipped defaults done");
    for (int i = 0; i < 6; i++) wr(UA[i], UA[i][7:0] ^ 8'ha5);
    for (int i = 0; i < 6; i++) rchk(UA[i], UA[i][7:0] ^ 8'ha5, "user_mem");
    $display("Test user memory done");
    for (int k = 0; k < 8; k++) begin
      wr(piodm_pkg::REGNUM_FIRST + 9'(k), ~REG_NUMBER[8*k+:8]);
      rchk(piodm_pkg::REGNUM_FIRST + 9'(k), REG_NUMBER[8*k+:8], "reg_number");
    end
    for (int i = 0; i < 7; i++) begin
      wr(RSV[i], 8'hff);
      rchk(RSV[i], 8'h00, "reserved");
    end
    $display("Test read-only and reserved done");
    for (int i = 0; i < 6; i++) wr(piodm_pkg::DEF_LEVEL_LO + 9'(i), WV[i]);
    for (int i = 0; i < 6; i++) begin
      rchk(piodm_pkg::DEF_LEVEL_LO + 9'(i), EV[i], "default_rw");
    end
    pwr_reset();
    for (int i = 0; i < 6; i++) begin
      rchk(piodm_pkg::OUT_LEVEL_LO + 9'(i), EV[i], "power_copy");
    end
    // Open drain everywhere: only outputs at level 0 drive
    `CHK("line_oe", 12'h4a0, line_oe)
    `CHK("line_out", 12'h35a, line_out)
    `CHK("drive_mode", 1'b0, drive_mode)
    $display("Test programmed defaults done");
    @(posedge clk);
    ext_en <= 12'haf0;
    ext_drive <= 12'h860;
    repeat (4) @(posedge clk);
    rchk(piodm_pkg::LINE_SENSE_LO, 8'h73, "sense_lo");
    rchk(piodm_pkg::LINE_SENSE_HI, 8'h08, "sense_hi");
    wr(piodm_pkg::INVERT_TYPE_MODE, 8'h80);
    #1;
    `CHK("line_oe", 12'h5f0, line_oe)
    `CHK("drive_mode", 1'b1, drive_mode)
    repeat (4) @(posedge clk);
    rchk(piodm_pkg::LINE_SENSE_HI, 8'h09, "sense_hi");
    wr(piodm_pkg::LINE_SENSE_LO, 8'hff);
    rchk(piodm_pkg::LINE_SENSE_LO, 8'h63, "sense_lo");
    $display("Test line sense done");
    @(posedge clk);
    alarm_set <= 8'h81;
    @(posedge clk);
    alarm_set <= 8'h00;
    rchk(piodm_pkg::ALARM_STATUS, 8'h81, "alarm_set");
    wr(piodm_pkg::ALARM_STATUS, 8'h01);
    rchk(piodm_pkg::ALARM_STATUS, 8'h80, "alarm_clear");
    wr(piodm_pkg::MULTIFUNCTION_SETUP, 8'ha5);
    pwr_reset();
    // Battery-backed bytes survive a power-up reset
    rchk(piodm_pkg::ALARM_STATUS, 8'h80, "alarm_kept");
    rchk(piodm_pkg::MULTIFUNCTION_SETUP, 8'ha5, "mf_setup");
    `CHK("mf_setup_port", 8'ha5, mf_setup)
    $display("Test alarm and status done");
    tally_and_finish();
  end
endmodule
